// file: watchdog_prescale_timeout.sv
`timescale 1ns/10ps
// watchdog time-out selection: divided slow clock, two equal intervals
module watchdog_prescale_timeout #(
  parameter int unsigned BASE_LOG2 = wdt_pkg::BASE_CYCLES_LOG2,
  parameter int unsigned RATIO_BY13 = wdt_pkg::DIV_RATIO_BY13,
  parameter int unsigned RATIO_BY15 = wdt_pkg::DIV_RATIO_BY15
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic slow_osc_clock,
  input wire logic [wdt_pkg::DIV_SEL_W-1:0] div_sel,
  input wire logic period_select_bit3,
  input wire logic period_select_bit2,
  input wire logic period_select_bit1,
  input wire logic period_select_bit0,
  input wire logic wdt_enable,
  input wire logic wdt_clear,
  output logic early_warning,
  output logic timeout,
  output logic final_phase,
  output logic config_err,
  output logic watchdog_count_clock
);

  // widest interval is the base shifted by the largest code
  localparam int unsigned PH_W = BASE_LOG2 + 9;

  typedef struct packed {
    logic osc_s1;
    logic osc_s2;
    logic osc_s3;
    logic [wdt_pkg::PERIOD_W-1:0] period;
    logic [wdt_pkg::DIV_SEL_W-1:0] div;
    logic enabled;
    wdt_pkg::phase_t phase;
    logic [PH_W-1:0] cnt;
    logic early;
    logic tout;
    logic cfg_err;
    logic cnt_clk;
    logic fin;
  } wdt_state_t;

  wdt_state_t st_r;
  wdt_state_t st_nxt;

  logic [wdt_pkg::PERIOD_W-1:0] period_in;
  logic osc_tick;
  logic count_tick;
  logic div_valid;
  logic period_ok;
  logic restart;
  logic [PH_W-1:0] limit;

  // shortened bases are allowed for simulation, but must stay positive
  initial begin
    if (BASE_LOG2 < 1 || BASE_LOG2 > wdt_pkg::BASE_CYCLES_LOG2) begin
      $error("watchdog_prescale_timeout: BASE_LOG2 out of range");
    end
  end

  assign period_in = {period_select_bit3, period_select_bit2,
                      period_select_bit1, period_select_bit0};

  // oscillator edge seen only after the two synchroniser stages
  assign osc_tick = st_r.osc_s2 & ~st_r.osc_s3;

  // reserved codes above nine select no interval
  assign period_ok = (period_in <= wdt_pkg::PERIOD_MAX_CODE);

  // any clear, any change of period or divider, or a disable restarts the count
  assign restart = wdt_clear || (period_in != st_r.period)
                   || (div_sel != st_r.div) || !wdt_enable;

  // last count of one interval: 2^(base+code) - 1 watchdog clock cycles
  function automatic logic [PH_W-1:0] interval_last(input logic [wdt_pkg::PERIOD_W-1:0] code);
    logic [PH_W:0] one_hot;
    one_hot = (PH_W+1)'(1) << (BASE_LOG2 + int'(code));
    interval_last = PH_W'(one_hot - (PH_W+1)'(1));
  endfunction : interval_last

  assign limit = interval_last(st_r.period);

  prescale_divider #(
    .CNT_W(wdt_pkg::DIV_CNT_W),
    .RATIO_A(RATIO_BY13),
    .RATIO_B(RATIO_BY15)
  ) u_div (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .osc_tick(osc_tick),
    .div_sel(div_sel),
    .restart(restart),
    .count_tick(count_tick),
    .div_valid(div_valid)
  );

  // next-state logic for the whole watchdog
  always_comb begin
    st_nxt = st_r;
    st_nxt.osc_s1 = slow_osc_clock;
    st_nxt.osc_s2 = st_r.osc_s1;
    st_nxt.osc_s3 = st_r.osc_s2;
    st_nxt.period = period_in;
    st_nxt.div = div_sel;
    st_nxt.enabled = wdt_enable;
    st_nxt.early = 1'b0;
    st_nxt.tout = 1'b0;
    st_nxt.cfg_err = wdt_enable && (!period_ok || !div_valid);
    // the count clock out toggles once per divided tick, a visible half-rate copy
    if (count_tick) begin
      st_nxt.cnt_clk = ~st_r.cnt_clk;
    end
    if (restart || !period_ok) begin
      // both intervals start again from zero; reserved codes hold here
      st_nxt.cnt = '0;
      st_nxt.phase = (wdt_enable && period_ok) ? wdt_pkg::PH_EARLY : wdt_pkg::PH_IDLE;
    end else begin
      unique case (st_r.phase)
        wdt_pkg::PH_IDLE: begin
          st_nxt.cnt = '0;
          st_nxt.phase = wdt_pkg::PH_EARLY;
        end
        wdt_pkg::PH_EARLY: begin
          if (count_tick) begin
            if (st_r.cnt == limit) begin
              // first interval done: warn, then count the same length again
              st_nxt.early = 1'b1;
              st_nxt.cnt = '0;
              st_nxt.phase = wdt_pkg::PH_FINAL;
            end else begin
              st_nxt.cnt = st_r.cnt + PH_W'(1);
            end
          end
        end
        wdt_pkg::PH_FINAL: begin
          if (count_tick) begin
            if (st_r.cnt == limit) begin
              // second equal interval done: twice the selected count in total
              st_nxt.tout = 1'b1;
              st_nxt.cnt = '0;
              st_nxt.phase = wdt_pkg::PH_EARLY;
            end else begin
              st_nxt.cnt = st_r.cnt + PH_W'(1);
            end
          end
        end
        default: begin
          // the unused code 2'h2 falls back to a fresh start
          st_nxt.cnt = '0;
          st_nxt.phase = wdt_pkg::PH_IDLE;
        end
      endcase
    end
    // registered copy of the phase decode keeps the output glitch free
    st_nxt.fin = (st_nxt.phase == wdt_pkg::PH_FINAL);
  end

  // single state register; ce low freezes everything, synchronisers too
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r.osc_s1 <= 1'b0;
      st_r.osc_s2 <= 1'b0;
      st_r.osc_s3 <= 1'b0;
      st_r.period <= wdt_pkg::PERIOD_RST;
      st_r.div <= wdt_pkg::DIV_SEL_RST;
      st_r.enabled <= 1'b0;
      st_r.phase <= wdt_pkg::PH_IDLE;
      st_r.cnt <= '0;
      st_r.early <= 1'b0;
      st_r.tout <= 1'b0;
      st_r.cfg_err <= 1'b0;
      st_r.cnt_clk <= 1'b0;
      st_r.fin <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  // every output is a field of the state register
  assign early_warning = st_r.early;
  assign timeout = st_r.tout;
  assign final_phase = st_r.fin;
  assign config_err = st_r.cfg_err;
  assign watchdog_count_clock = st_r.cnt_clk;

endmodule : watchdog_prescale_timeout

// file: wdt_pkg.sv
package wdt_pkg;

  // divider setting field and the two documented settings
  localparam int unsigned DIV_SEL_W = 3;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_BY13 = 3'h6;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_BY15 = 3'h7;
  localparam int unsigned DIV_RATIO_BY13 = 13;
  localparam int unsigned DIV_RATIO_BY15 = 15;
  localparam int unsigned DIV_CNT_W = 4;

  // period select field: code 0 is 2^11 watchdog clock cycles, code 9 is 2^20
  localparam int unsigned PERIOD_W = 4;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX_CODE = 4'h9;
  localparam int unsigned BASE_CYCLES_LOG2 = 11;
  localparam int unsigned BASE_CYCLES = 2048;
  localparam int unsigned MAX_CYCLES = 1048576;

  // values after reset
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 4'h0;
  localparam logic [DIV_SEL_W-1:0] DIV_SEL_RST = 3'h0;

  // interval phases, gray along idle -> early -> final
  typedef enum logic [1:0] {
    PH_IDLE  = 2'h0,
    PH_EARLY = 2'h1,
    PH_FINAL = 2'h3
  } phase_t;

endpackage : wdt_pkg

// file: prescale_divider.sv
`timescale 1ns/10ps
// divides the slow oscillator tick stream down to the watchdog count clock
module prescale_divider #(
  parameter int unsigned CNT_W = wdt_pkg::DIV_CNT_W,
  parameter int unsigned RATIO_A = wdt_pkg::DIV_RATIO_BY13,
  parameter int unsigned RATIO_B = wdt_pkg::DIV_RATIO_BY15
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic osc_tick,
  input wire logic [wdt_pkg::DIV_SEL_W-1:0] div_sel,
  input wire logic restart,
  output logic count_tick,
  output logic div_valid
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } div_state_t;

  div_state_t st_r;
  div_state_t st_nxt;
  logic [CNT_W-1:0] last;
  logic known;

  // the counter must hold the largest ratio minus one
  initial begin
    if (RATIO_A < 2 || RATIO_B < 2 || RATIO_A > (1 << CNT_W) || RATIO_B > (1 << CNT_W)) begin
      $error("prescale_divider: ratio does not fit counter");
    end
  end

  // ratio select; unknown settings stall the count clock
  always_comb begin
    last = '0;
    known = 1'b0;
    unique case (div_sel)
      wdt_pkg::DIV_SEL_BY13: begin
        last = CNT_W'(RATIO_A - 1);
        known = 1'b1;
      end
      wdt_pkg::DIV_SEL_BY15: begin
        last = CNT_W'(RATIO_B - 1);
        known = 1'b1;
      end
      default: begin
        last = '0;
        known = 1'b0;
      end
    endcase
  end

  // modulo counter on oscillator ticks, one tick out per wrap
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (restart || !known) begin
      st_nxt.cnt = '0;
    end else if (osc_tick) begin
      if (st_r.cnt >= last) begin
        st_nxt.cnt = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign count_tick = st_r.tick;
  // decoded directly, so the error flag follows a bad setting without an extra cycle of lag
  assign div_valid = known;

endmodule : prescale_divider

// file: watchdog_prescale_timeout_monitor.sv
`timescale 1ns/10ps
// port-level checks on the two-phase time-out sequence
module wdt_monitor #(
  parameter int unsigned BASE_LOG2 = 11,
  parameter int unsigned RATIO_BY13 = 13,
  parameter int unsigned RATIO_BY15 = 15
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [wdt_pkg::DIV_SEL_W-1:0] div_sel,
  input wire logic period_select_bit3,
  input wire logic period_select_bit2,
  input wire logic period_select_bit1,
  input wire logic period_select_bit0,
  input wire logic wdt_enable,
  input wire logic wdt_clear,
  input wire logic early_warning,
  input wire logic timeout,
  input wire logic final_phase,
  input wire logic config_err
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // a legal setup is a documented divider and a code of 9 or less
  wire [3:0] code = {period_select_bit3, period_select_bit2, period_select_bit1, period_select_bit0};
  wire good = code <= 4'h9 && (div_sel == 3'h6 || div_sel == 3'h7);
  // count ticks are many clocks apart, so events never crowd
  sequence quiet_run;
    (!early_warning && !timeout) [*8];
  endsequence
  chk_early_spacing: assert property (early_warning |=> quiet_run)
    else $error("event too soon after early warning");
  chk_final_before_timeout: assert property (timeout |-> $past(final_phase))
    else $error("timeout outside final phase");
  chk_reserved_flag: assert property (ce && wdt_enable && !good |=> config_err)
    else $error("reserved setting not flagged");
  chk_valid_no_flag: assert property (ce && wdt_enable && good |=> !config_err)
    else $error("legal setting flagged");
  chk_clear_quiet: assert property (ce && wdt_clear |=> !early_warning && !timeout)
    else $error("event right after clear");
  chk_disable_idle: assert property (ce && !wdt_enable |=> !final_phase && !timeout)
    else $error("activity while disabled");
  chk_final_after_early: assert property (early_warning |-> final_phase)
    else $error("early warning without final phase");
endmodule : wdt_monitor

bind watchdog_prescale_timeout wdt_monitor #(.BASE_LOG2(BASE_LOG2), .RATIO_BY13(RATIO_BY13),
  .RATIO_BY15(RATIO_BY15)) mon (.clk(clk), .rstn(rstn), .ce(ce), .div_sel(div_sel),
  .period_select_bit3(period_select_bit3), .period_select_bit2(period_select_bit2),
  .period_select_bit1(period_select_bit1), .period_select_bit0(period_select_bit0),
  .wdt_enable(wdt_enable), .wdt_clear(wdt_clear), .early_warning(early_warning),
  .timeout(timeout), .final_phase(final_phase), .config_err(config_err));

// file: test_watchdog_prescale_timeout.sv
`timescale 1ns/10ps
module test_watchdog_prescale_timeout;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic osc = 1'b0;
  logic [2:0] div_sel = 3'h6;
  logic [3:0] code = 4'h0;
  logic en = 1'b0;
  logic clr = 1'b0;
  logic ce = 1'b1;
  logic early_warning, timeout, final_phase, config_err;
  logic wcc;
  logic wcc_q = 1'b0;
  logic fp_ew;
  logic fp_to;
  int n_tg = 0;
  int n_errors = 0;
  int cmp_count = 0;
  int rises = 0;
  int ew_at = 0;
  int to_at = 0;
  int n_ew = 0;
  int n_to = 0;
  logic [31:0] seed = 32'h0000004E;
  always #5 clk = ~clk;
  watchdog_prescale_timeout #(.BASE_LOG2(1)) dut (.clk(clk), .rstn(rstn), .ce(ce),
    .slow_osc_clock(osc), .div_sel(div_sel), .period_select_bit3(code[3]),
    .period_select_bit2(code[2]), .period_select_bit1(code[1]), .period_select_bit0(code[0]),
    .wdt_enable(en), .wdt_clear(clr), .early_warning(early_warning), .timeout(timeout),
    .final_phase(final_phase), .config_err(config_err), .watchdog_count_clock(wcc));
  // sampled on the falling edge, away from the edge that launches the outputs
  always @(negedge clk) begin
    if (early_warning === 1'b1) begin
      n_ew++;
      ew_at = rises;
      fp_ew = final_phase;
    end
    if (timeout === 1'b1) begin
      n_to++;
      to_at = rises;
      fp_to = final_phase;
    end
    if (wcc !== wcc_q) begin
      n_tg++;
    end
    wcc_q = wcc;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // oscillator edges per interval, with the shortened base of 2 ticks
  function automatic int iv_of(input logic [2:0] d, input logic [3:0] c);
    int r;
    r = (d == wdt_pkg::DIV_SEL_BY13) ? wdt_pkg::DIV_RATIO_BY13 : wdt_pkg::DIV_RATIO_BY15;
    return r << (1 + c);
  endfunction : iv_of
  task automatic check_int(input string what, input int exp, input int got);
    cmp_count++;
    if (exp != got) begin
      n_errors++;
      $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
    end
  endtask : check_int
  task automatic check_bit(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check_bit
  // one oscillator period; half width random but longer than the sync delay
  task automatic step();
    int h;
    h = 6 + xs() % 4;
    osc <= 1'b1;
    rises++;
    repeat (h) @(posedge clk);
    osc <= 1'b0;
    repeat (h) @(posedge clk);
  endtask : step
  task automatic start(input logic [2:0] d, input logic [3:0] c);
    div_sel <= d;
    code <= c;
    en <= 1'b1;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (6) @(posedge clk);
    rises = 0;
    n_ew = 0;
    n_to = 0;
    n_tg = 0;
  endtask : start
  task automatic run(input logic [2:0] d, input logic [3:0] c, input int clr_at);
    int iv;
    iv = iv_of(d, c);
    start(d, c);
    if (clr_at > 0) begin
      repeat (clr_at) step();
      start(d, c);
    end
    repeat (2 * iv) step();
    check_int("early count", 1, n_ew);
    check_int("early position", iv, ew_at);
    check_int("timeout count", 1, n_to);
    check_int("timeout position", 2 * iv, to_at);
    check_bit("final_phase at early", 1'b1, fp_ew);
    check_bit("final_phase at timeout", 1'b0, fp_to);
    check_int("count clock toggles", 4 << c, n_tg);
    $display("test div %0d code %0d done", d, c);
  endtask : run
  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    run(wdt_pkg::DIV_SEL_BY13, 4'h0, 0);
    run(wdt_pkg::DIV_SEL_BY15, 4'h0, 0);
    run(wdt_pkg::DIV_SEL_BY13, 4'h1, iv_of(3'h6, 4'h1) - 1);
    repeat (3) run(3'h6 + 3'(xs() % 2), 4'(xs() % 3), 0);
    // reserved codes and unknown dividers must never count
    for (int i = 0; i < 12; i++) begin
      start(i < 6 ? 3'(i) : 3'h7, i < 6 ? 4'h0 : 4'(i + 4));
      repeat (32) step();
      check_bit("config_err", 1'b1, config_err);
      check_int("events", 0, n_ew + n_to);
    end
    $display("test reserved done");
    // clock enable low: oscillator edges in the frozen span must not count
    start(3'h6, 4'h0);
    ce <= 1'b0;
    repeat (40) step();
    ce <= 1'b1;
    repeat (iv_of(3'h6, 4'h0)) step();
    check_int("frozen early count", 1, n_ew);
    check_int("frozen early position", 40 + iv_of(3'h6, 4'h0), ew_at);
    $display("test freeze done");
    start(3'h6, 4'h0);
    en <= 1'b0;
    repeat (60) step();
    check_int("disabled events", 0, n_ew + n_to);
    check_bit("disabled final_phase", 1'b0, final_phase);
    $display("test disable done");
    report_and_stop();
  end
endmodule : test_watchdog_prescale_timeout
